/* File: hdl/awc_pkg.sv */
// Purpose: Constants and types for the area wait configuration block.
// Assumes: AXI4-Lite register access with 32-bit data words.
// Notes: Eight external areas, each with a cycle length and wait count.
package awc_pkg;

  localparam int AWC_ADDR_W = 4;
  localparam int AWC_AREAS = 8;
  localparam int AWC_WFIELD_W = 3;
  localparam int AWC_WFIELD_STRIDE = 4;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] AWC_OFS_AREA_ACCESS_STATE_CONTROL = 4'h0;
  localparam logic [3:0] AWC_OFS_WAIT_COUNT_AREAS_7_TO_4 = 4'h4;
  localparam logic [3:0] AWC_OFS_WAIT_COUNT_AREAS_3_TO_0 = 4'h8;
  localparam logic [3:0] AWC_OFS_STATUS = 4'hC;

  localparam logic [15:0] AWC_ASC_RESET = 16'hFF00;
  localparam logic [15:0] AWC_WAIT_RESET = 16'h7777;
  localparam logic [15:0] AWC_WAIT_MASK = 16'h7777;

  localparam int AWC_STS_STATE_LSB = 0;
  localparam int AWC_STS_AREA_LSB = 4;
  localparam int AWC_STS_BUSY_BIT = 8;

  localparam logic [1:0] AWC_RESP_OKAY = 2'h0;
  localparam logic [1:0] AWC_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Bus cycle states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AWC_ST_IDLE = 3'h0,
    AWC_ST_T1 = 3'h1,
    AWC_ST_T2 = 3'h2,
    AWC_ST_TW = 3'h3,
    AWC_ST_T3 = 3'h4
  } awc_state_type;

endpackage

/* File: hdl/awc_cycle_timer.sv */
// Purpose: Sequences one external bus cycle from the per-area settings.
// Assumes: Requests come from logic on the same clock.
// Notes: Settings are latched when a cycle starts.
`timescale 1ns/100ps
module awc_cycle_timer
  import awc_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic req,
  input logic [2:0] area,
  input logic [7:0] three_state,
  input logic [15:0] wait_hi,
  input logic [15:0] wait_lo,
  output awc_state_type state_ff,
  output logic [2:0] area_ff,
  output logic busy_ff,
  output logic strobe_ff,
  output logic done_ff
);

  logic [AWC_WFIELD_W-1:0] wait_of [AWC_AREAS];
  awc_state_type nxt_state;
  logic [2:0] nxt_area;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic long_ff;
  logic nxt_long;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < AWC_AREAS / 2; gi++) begin : g_field
      assign wait_of[gi] =
        wait_lo[gi*AWC_WFIELD_STRIDE +: AWC_WFIELD_W];
      assign wait_of[gi+4] =
        wait_hi[gi*AWC_WFIELD_STRIDE +: AWC_WFIELD_W];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Settings are captured at the start so a register write during a
  // cycle cannot stretch or cut the cycle under way.
  always_comb begin
    nxt_state = state_ff;
    nxt_area = area_ff;
    nxt_cnt = cnt_ff;
    nxt_long = long_ff;
    case (state_ff)
      AWC_ST_IDLE: begin
        if (req) begin
          nxt_state = AWC_ST_T1;
          nxt_area = area;
          nxt_long = three_state[area];
          nxt_cnt = three_state[area] ? wait_of[area] : 3'h0;
        end
      end
      AWC_ST_T1: begin
        nxt_state = AWC_ST_T2;
      end
      AWC_ST_T2: begin
        if (!long_ff) begin
          nxt_state = AWC_ST_IDLE;
        end else if (cnt_ff != 3'h0) begin
          nxt_state = AWC_ST_TW;
        end else begin
          nxt_state = AWC_ST_T3;
        end
      end
      AWC_ST_TW: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h1) begin
          nxt_state = AWC_ST_T3;
        end
      end
      AWC_ST_T3: begin
        nxt_state = AWC_ST_IDLE;
      end
      default: begin
        nxt_state = AWC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= AWC_ST_IDLE;
      area_ff <= 3'h0;
      cnt_ff <= 3'h0;
      long_ff <= 1'b0;
      busy_ff <= 1'b0;
      strobe_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      area_ff <= nxt_area;
      cnt_ff <= nxt_cnt;
      long_ff <= nxt_long;
      busy_ff <= (nxt_state != AWC_ST_IDLE);
      strobe_ff <= (nxt_state == AWC_ST_T2) || (nxt_state == AWC_ST_TW)
        || (nxt_state == AWC_ST_T3);
      done_ff <= (state_ff != AWC_ST_IDLE) && (nxt_state == AWC_ST_IDLE);
    end
  end

endmodule

/* File: hdl/awc_top.sv */
// Purpose: Per-area access state and wait count registers with cycle timer.
// Assumes: AXI4-Lite master keeps one write and one read outstanding.
// Notes: Writes answer one cycle after both halves are held.
`timescale 1ns/100ps
module awc_top
  import awc_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic [AWC_ADDR_W-1:0] awaddr,
  input logic [2:0] awprot,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [AWC_ADDR_W-1:0] araddr,
  input logic [2:0] arprot,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic cyc_req,
  input logic [2:0] cyc_area,
  output awc_state_type cyc_state,
  output logic [2:0] cyc_cur_area,
  output logic cyc_busy,
  output logic cyc_strobe,
  output logic cyc_done,
  output logic [7:0] area_three_state_sel,
  output logic [15:0] wait_count_hi,
  output logic [15:0] wait_count_lo
);

  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [AWC_ADDR_W-1:0] wofs_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [7:0] area_access_state_control_ff;
  logic [15:0] wait_count_areas_7_to_4_ff;
  logic [15:0] wait_count_areas_3_to_0_ff;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic nxt_aw_hold;
  logic nxt_w_hold;
  logic nxt_rvalid;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [15:0] sts_word;

  // ----------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign area_three_state_sel = area_access_state_control_ff;
  assign wait_count_hi = wait_count_areas_7_to_4_ff;
  assign wait_count_lo = wait_count_areas_3_to_0_ff;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are held separately so the master may offer them
  // in either order; the write commits once both are present.
  assign aw_take = awvalid && awready_ff;
  assign w_take = wvalid && wready_ff;
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    if (do_write) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
    end
    if (aw_take) begin
      nxt_aw_hold = 1'b1;
    end
    if (w_take) begin
      nxt_w_hold = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      wofs_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= !nxt_aw_hold;
      wready_ff <= !nxt_w_hold;
      if (aw_take) begin
        wofs_ff <= awaddr;
      end
      if (w_take) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
    end
  end

  always_comb begin
    if (wofs_ff == AWC_OFS_AREA_ACCESS_STATE_CONTROL) begin
      wr_hit = 1'b1;
    end else if (wofs_ff == AWC_OFS_WAIT_COUNT_AREAS_7_TO_4) begin
      wr_hit = 1'b1;
    end else if (wofs_ff == AWC_OFS_WAIT_COUNT_AREAS_3_TO_0) begin
      wr_hit = 1'b1;
    end else if (wofs_ff == AWC_OFS_STATUS) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= AWC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? AWC_RESP_OKAY : AWC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // The low byte of the select register has no storage at all.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      area_access_state_control_ff <= AWC_ASC_RESET[15:8];
    end else if (do_write && wstrb_ff[1] &&
                 wofs_ff == AWC_OFS_AREA_ACCESS_STATE_CONTROL) begin
      area_access_state_control_ff <= wdata_ff[15:8];
    end
  end

  // Reserved positions are forced to zero on every write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_count_areas_7_to_4_ff <= AWC_WAIT_RESET;
    end else if (do_write &&
                 wofs_ff == AWC_OFS_WAIT_COUNT_AREAS_7_TO_4) begin
      if (wstrb_ff[0]) begin
        wait_count_areas_7_to_4_ff[7:0] <=
          wdata_ff[7:0] & AWC_WAIT_MASK[7:0];
      end
      if (wstrb_ff[1]) begin
        wait_count_areas_7_to_4_ff[15:8] <=
          wdata_ff[15:8] & AWC_WAIT_MASK[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_count_areas_3_to_0_ff <= AWC_WAIT_RESET;
    end else if (do_write &&
                 wofs_ff == AWC_OFS_WAIT_COUNT_AREAS_3_TO_0) begin
      if (wstrb_ff[0]) begin
        wait_count_areas_3_to_0_ff[7:0] <=
          wdata_ff[7:0] & AWC_WAIT_MASK[7:0];
      end
      if (wstrb_ff[1]) begin
        wait_count_areas_3_to_0_ff[15:8] <=
          wdata_ff[15:8] & AWC_WAIT_MASK[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_take = arvalid && arready_ff;
  assign nxt_rvalid = ar_take || (rvalid_ff && !rready);

  always_comb begin
    sts_word = 16'h0;
    sts_word[AWC_STS_STATE_LSB +: 3] = cyc_state;
    sts_word[AWC_STS_AREA_LSB +: 3] = cyc_cur_area;
    sts_word[AWC_STS_BUSY_BIT] = cyc_busy;
  end

  always_comb begin
    rd_hit = 1'b1;
    if (araddr == AWC_OFS_AREA_ACCESS_STATE_CONTROL) begin
      rd_word = {16'h0, area_access_state_control_ff, 8'h00};
    end else if (araddr == AWC_OFS_WAIT_COUNT_AREAS_7_TO_4) begin
      rd_word = {16'h0, wait_count_areas_7_to_4_ff};
    end else if (araddr == AWC_OFS_WAIT_COUNT_AREAS_3_TO_0) begin
      rd_word = {16'h0, wait_count_areas_3_to_0_ff};
    end else if (araddr == AWC_OFS_STATUS) begin
      rd_word = {16'h0, sts_word};
    end else begin
      rd_word = 32'h0;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= AWC_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit ? AWC_RESP_OKAY : AWC_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle timer
  // ----------------------------------------------------------------
  awc_cycle_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(cyc_req),
    .area(cyc_area),
    .three_state(area_access_state_control_ff),
    .wait_hi(wait_count_areas_7_to_4_ff),
    .wait_lo(wait_count_areas_3_to_0_ff),
    .state_ff(cyc_state),
    .area_ff(cyc_cur_area),
    .busy_ff(cyc_busy),
    .strobe_ff(cyc_strobe),
    .done_ff(cyc_done)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic acc;
  logic hlp_long_ff;
  logic [2:0] hlp_wait_ff;
  logic [2:0] tw_cnt_ff;
  logic [3:0] rofs_ff;
  logic [15:0] wsel;

  assign acc = cyc_req && (cyc_state == AWC_ST_IDLE);
  assign wsel = cyc_area[2] ? wait_count_areas_7_to_4_ff
                            : wait_count_areas_3_to_0_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hlp_long_ff <= 1'b0;
      hlp_wait_ff <= 3'h0;
      tw_cnt_ff <= 3'h0;
      rofs_ff <= 4'h0;
    end else begin
      if (acc) begin
        hlp_long_ff <= area_access_state_control_ff[cyc_area];
        hlp_wait_ff <= wsel[4*cyc_area[1:0] +: 3];
        tw_cnt_ff <= 3'h0;
      end else if (cyc_state == AWC_ST_TW) begin
        tw_cnt_ff <= tw_cnt_ff + 3'h1;
      end
      if (ar_take) begin
        rofs_ff <= araddr;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_two_state;
    (acc && !area_access_state_control_ff[cyc_area]) |=>
      (cyc_state == AWC_ST_T1) ##1 (cyc_state == AWC_ST_T2)
      ##1 (cyc_state == AWC_ST_IDLE && cyc_done);
  endproperty
  a_two_state: assert property (p_two_state)
    else $error("Two-state cycle has wrong length.");

  property p_no_wait_short;
    (cyc_state == AWC_ST_TW || cyc_state == AWC_ST_T3) |-> hlp_long_ff;
  endproperty
  a_no_wait_short: assert property (p_no_wait_short)
    else $error("Wait or third state in a two-state cycle.");

  property p_three_state;
    (acc && area_access_state_control_ff[cyc_area]) |=>
      (cyc_state == AWC_ST_T1) ##1 (cyc_state == AWC_ST_T2)
      ##1 (cyc_state == AWC_ST_TW || cyc_state == AWC_ST_T3);
  endproperty
  a_three_state: assert property (p_three_state)
    else $error("Three-state cycle did not reach a third state.");

  property p_wait_len;
    (cyc_state == AWC_ST_T3) |-> (tw_cnt_ff == hlp_wait_ff);
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("Inserted wait count differs from the latched field.");

  property p_strobe;
    (cyc_state == AWC_ST_T2 || cyc_state == AWC_ST_TW ||
     cyc_state == AWC_ST_T3) |-> cyc_strobe ##0 $stable(cyc_cur_area);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("Strobe not held through the wait states.");

  property p_area_sel;
    acc |=> (cyc_cur_area == $past(cyc_area)) && cyc_busy;
  endproperty
  a_area_sel: assert property (p_area_sel)
    else $error("Cycle did not take the requested area.");

  property p_asc_reset;
    !$past(aresetn) |-> (area_access_state_control_ff == 8'hFF);
  endproperty
  a_asc_reset: assert property (p_asc_reset)
    else $error("Select bits not all one after reset.");

  property p_asc_low;
    (rvalid_ff && rofs_ff == AWC_OFS_AREA_ACCESS_STATE_CONTROL) |->
      (rdata_ff[7:0] == 8'h00);
  endproperty
  a_asc_low: assert property (p_asc_low)
    else $error("Select register low byte not zero.");

  property p_wait_resv;
    (rvalid_ff && (rofs_ff == AWC_OFS_WAIT_COUNT_AREAS_7_TO_4 ||
     rofs_ff == AWC_OFS_WAIT_COUNT_AREAS_3_TO_0)) |->
      ((rdata_ff[15:0] & ~AWC_WAIT_MASK) == 16'h0);
  endproperty
  a_wait_resv: assert property (p_wait_resv)
    else $error("Reserved wait register bits read nonzero.");

  property p_hi_write;
    (do_write && wstrb_ff == 4'hF &&
     wofs_ff == AWC_OFS_WAIT_COUNT_AREAS_7_TO_4) |=>
      (wait_count_areas_7_to_4_ff == ($past(wdata_ff[15:0]) &
       AWC_WAIT_MASK)) ##0 bvalid_ff;
  endproperty
  a_hi_write: assert property (p_hi_write)
    else $error("Upper wait register write not stored.");

  property p_lo_write;
    (do_write && wstrb_ff == 4'hF &&
     wofs_ff == AWC_OFS_WAIT_COUNT_AREAS_3_TO_0) |=>
      (wait_count_areas_3_to_0_ff == ($past(wdata_ff[15:0]) &
       AWC_WAIT_MASK)) ##0 bvalid_ff;
  endproperty
  a_lo_write: assert property (p_lo_write)
    else $error("Lower wait register write not stored.");

  property p_keep_old;
    (cyc_state == AWC_ST_TW) |=>
      (cyc_state == AWC_ST_TW || cyc_state == AWC_ST_T3)
      ##0 $stable(hlp_wait_ff);
  endproperty
  a_keep_old: assert property (p_keep_old)
    else $error("Running cycle left the wait states early.");

endmodule

/* File: dv/awc_ext_dev.sv */
// Purpose: External device model that times each bus cycle it sees.
// Assumes: Cycle outputs are flops on aclk.
// Notes: Reports cycle length, strobe length and area once per cycle.
`timescale 1ns/100ps
module awc_ext_dev (
  input logic aclk,
  input logic aresetn,
  input logic cyc_busy,
  input logic cyc_strobe,
  input logic cyc_done,
  input logic [2:0] cyc_cur_area,
  output logic meas_valid_ff,
  output logic [2:0] meas_area_ff,
  output logic [3:0] meas_busy_ff,
  output logic [3:0] meas_strobe_ff
);
  logic [3:0] n_busy_ff;
  logic [3:0] n_strobe_ff;

  // ----------------------------------------------------------------
  // Cycle timing
  // ----------------------------------------------------------------
  // The device sees busy, strobe, done and area; it times busy and strobe separately.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_valid_ff <= 1'b0;
      n_busy_ff <= 4'h0;
      n_strobe_ff <= 4'h0;
    end else if (cyc_done) begin
      meas_valid_ff <= 1'b1;
      meas_busy_ff <= n_busy_ff;
      meas_strobe_ff <= n_strobe_ff;
      n_busy_ff <= 4'h0;
      n_strobe_ff <= 4'h0;
    end else begin
      meas_valid_ff <= 1'b0;
      if (cyc_busy) begin
        n_busy_ff <= n_busy_ff + 4'h1;
        meas_area_ff <= cyc_cur_area;
      end
      if (cyc_strobe) begin
        n_strobe_ff <= n_strobe_ff + 4'h1;
      end
    end
  end
endmodule

/* File: dv/awc_top_tb_top.sv */
// Purpose: Self-checking bench for the area wait configuration block.
// Assumes: AXI4-Lite master with one write and one read at a time.
// Notes: Expected results queue up; a monitor compares them in order.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module awc_top_tb_top
  import awc_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cyc_req;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [2:0] cyc_area, cyc_cur_area, meas_area;
  logic awready, wready, bvalid, arready, rvalid;
  logic cyc_busy, cyc_strobe, cyc_done, meas_valid;
  logic [1:0] bresp, rresp, eb;
  awc_state_type cyc_state;
  logic [7:0] area_three_state_sel, sel_m;
  logic [15:0] wait_count_hi, wait_count_lo;
  logic [3:0] meas_busy, meas_strobe;
  logic [2:0] w_m [8];
  logic [33:0] er;
  logic [10:0] ec;
  logic [1:0] wq [$];
  logic [33:0] rq [$];
  logic [10:0] cq [$];
  int mismatches = 0;
  int n_checks = 0;

  awc_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cyc_req(cyc_req),
    .cyc_area(cyc_area), .cyc_state(cyc_state),
    .cyc_cur_area(cyc_cur_area), .cyc_busy(cyc_busy),
    .cyc_strobe(cyc_strobe), .cyc_done(cyc_done),
    .area_three_state_sel(area_three_state_sel),
    .wait_count_hi(wait_count_hi), .wait_count_lo(wait_count_lo));

  awc_ext_dev u_dev (.aclk(aclk), .aresetn(aresetn), .cyc_busy(cyc_busy),
    .cyc_strobe(cyc_strobe), .cyc_done(cyc_done),
    .cyc_cur_area(cyc_cur_area), .meas_valid_ff(meas_valid),
    .meas_area_ff(meas_area), .meas_busy_ff(meas_busy),
    .meas_strobe_ff(meas_strobe));

  // ----------------------------------------------------------------
  // Clock, reset and closing
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge aclk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d,
                        input logic [1:0] ex);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    wq.push_back(ex);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] ad, input logic [33:0] ex);
    rq.push_back(ex);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] pk_w(input int base);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < 4; k++) r[4*k +: 3] = w_m[base+k];
    return r;
  endfunction

  // Wait registers go first so a mid-cycle rewrite lands early.
  task automatic wr_all();
    axi_wr(AWC_OFS_WAIT_COUNT_AREAS_3_TO_0,
      pk_w(0) | ($urandom & 32'hFFFF8888), AWC_RESP_OKAY);
    axi_wr(AWC_OFS_WAIT_COUNT_AREAS_7_TO_4,
      pk_w(4) | ($urandom & 32'hFFFF8888), AWC_RESP_OKAY);
    axi_wr(AWC_OFS_AREA_ACCESS_STATE_CONTROL,
      {16'($urandom), sel_m, 8'($urandom)}, AWC_RESP_OKAY);
  endtask

  task automatic rd_all();
    axi_rd(AWC_OFS_AREA_ACCESS_STATE_CONTROL,
      {AWC_RESP_OKAY, 16'h0, sel_m, 8'h0});
    axi_rd(AWC_OFS_WAIT_COUNT_AREAS_7_TO_4, {AWC_RESP_OKAY, pk_w(4)});
    axi_rd(AWC_OFS_WAIT_COUNT_AREAS_3_TO_0, {AWC_RESP_OKAY, pk_w(0)});
  endtask

  task automatic run_cyc(input logic [2:0] ar, input logic s,
                         input logic [2:0] w);
    cq.push_back({ar, (s ? 4'(w) + 4'h3 : 4'h2),
      (s ? 4'(w) + 4'h2 : 4'h1)});
    @(posedge aclk);
    cyc_req <= 1'b1;
    cyc_area <= ar;
    do @(negedge aclk); while (!cyc_busy);
    @(posedge aclk);
    cyc_req <= 1'b0;
    cyc_area <= 3'($urandom);
    do @(negedge aclk); while (!cyc_done);
  endtask

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(negedge aclk) begin
    if (bvalid && bready) begin
      eb = (wq.size() > 0) ? wq.pop_front() : 2'h1;
      `CHK(bresp, eb)
    end
    if (rvalid && rready) begin
      er = (rq.size() > 0) ? rq.pop_front() : {2'h3, 32'h0};
      `CHK({rresp, rdata}, er)
    end
    if (meas_valid) begin
      ec = (cq.size() > 0) ? cq.pop_front() : 11'h7FF;
      `CHK({meas_area, meas_busy, meas_strobe}, ec)
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] a, w;
    logic s;
    {awvalid, wvalid, bready, arvalid, rready, cyc_req} = 6'h0;
    {awaddr, araddr, cyc_area, wdata} = '0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    sel_m = 8'hFF;
    for (int k = 0; k < 8; k++) w_m[k] = 3'h7;
    void'($urandom(32'h9CA11C92));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(area_three_state_sel, 8'hFF)
    `CHK({wait_count_hi, wait_count_lo}, 32'h77777777)
    rd_all();
    run_cyc(3'h5, 1'b1, 3'h7);
    axi_wr(4'h6, 32'h0, AWC_RESP_SLVERR);
    axi_wr(AWC_OFS_STATUS, 32'hFFFFFFFF, AWC_RESP_OKAY);
    axi_rd(4'h2, {AWC_RESP_SLVERR, 32'h0});
    wr_all();
    rd_all();
    for (int i = 0; i < 16; i++) begin
      a = (i < 8) ? 3'(i) : 3'($urandom);
      s = (i < 8) ? 1'(i) : 1'b1;
      w = (i < 8) ? 3'($urandom) : 3'(i);
      sel_m[a] = s;
      w_m[a] = w;
      wr_all();
      rd_all();
      run_cyc(a, s, w);
    end
    sel_m[2] = 1'b1;
    w_m[2] = 3'h6;
    wr_all();
    w_m[2] = 3'h1;
    fork
      run_cyc(3'h2, 1'b1, 3'h6);
      begin
        repeat (3) @(posedge aclk);
        wr_all();
      end
    join
    run_cyc(3'h2, 1'b1, 3'h1);
    axi_rd(AWC_OFS_STATUS, {AWC_RESP_OKAY, 32'h20});
    `CHK(area_three_state_sel, sel_m)
    `CHK({16'h0, wait_count_hi}, pk_w(4))
    `CHK({16'h0, wait_count_lo}, pk_w(0))
    repeat (4) @(posedge aclk);
    close_out();
  end
endmodule
